// ==== owe_pkg.sv ====
package owe_pkg;

  // Clock and timing figures; each cycle count derives from its time.
  localparam int CLK_PERIOD_NS    = 10;
  localparam int T_RESET_MIN_NS   = 480000;
  localparam int T_SLOT_SAMPLE_NS = 30000;
  localparam int T_PRES_DELAY_NS  = 30000;
  localparam int T_PRES_PULSE_NS  = 120000;
  localparam int RESET_CYC        = (T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CYC       = T_SLOT_SAMPLE_NS / CLK_PERIOD_NS;
  localparam int PRES_DELAY_CYC   = T_PRES_DELAY_NS / CLK_PERIOD_NS;
  localparam int PRES_PULSE_CYC   = T_PRES_PULSE_NS / CLK_PERIOD_NS;
  localparam int CNT_W            = 16;

  // Command codes.
  localparam logic [7:0] CMD_READ_ID   = 8'h33;
  localparam logic [7:0] CMD_MATCH_ID  = 8'h55;
  localparam logic [7:0] CMD_SKIP_ID   = 8'hCC;
  localparam logic [7:0] CMD_READ_MEM  = 8'hF0;
  localparam logic [7:0] CMD_READ_STAT = 8'hAA;
  localparam logic [7:0] CMD_WRITE_MEM = 8'h0F;
  localparam logic [7:0] CMD_WRITE_ST  = 8'h55;

  // Memory layout.
  localparam int          DATA_BYTES   = 192;
  localparam int          PAGE_BYTES   = 32;
  localparam logic [15:0] STATUS_BASE  = 16'h0100;
  localparam int          STATUS_BYTES = 8;
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
  localparam int          ID_BITS      = 64;

  // Reflected polynomials for least significant bit first shifting.
  localparam logic [15:0] CRC16_POLY = 16'hA001;
  localparam logic [7:0]  CRC8_POLY  = 8'h8C;

  // One-hot command interpreter states.
  typedef enum logic [10:0] {
    ST_WAIT  = 11'h001,
    ST_ROMC  = 11'h002,
    ST_ROMRD = 11'h004,
    ST_MATCH = 11'h008,
    ST_FUNC  = 11'h010,
    ST_ADDR  = 11'h020,
    ST_WDATA = 11'h040,
    ST_CRC   = 11'h080,
    ST_DATA  = 11'h100,
    ST_PROG  = 11'h200,
    ST_ONES  = 11'h400
  } owe_state_t;

  // One bit step of the 16-bit check.
  function automatic logic [15:0] crc16_bit(input logic [15:0] c, input logic b);
    logic [15:0] r;
    r = c >> 1;
    if (c[0] ^ b) begin
      r = r ^ CRC16_POLY;
    end
    return r;
  endfunction

  // 8-bit check over family code and serial, low bit first.
  function automatic logic [7:0] crc8_of56(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = ((c[0] ^ d[i]) != 1'b0) ? ((c >> 1) ^ CRC8_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// ==== owe_cmd.sv ====
module owe_cmd
  import owe_pkg::*;
#(
  parameter logic [7:0]  FAMILY_CODE = 8'h5A,           // Arbitrary value.
  parameter logic [47:0] SERIAL      = 48'h0000_0000_0001, // Arbitrary value.
  parameter int          RESET_CYCLES = RESET_CYC,
  parameter int          PRES_CYCLES  = PRES_PULSE_CYC,
  parameter int          SAMPLE_CYCLES = SAMPLE_CYC
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst_n,
  // Open-drain single wire data line.
  input  wire logic single_wire_data_line_in,
  output logic      single_wire_data_line_out,
  output logic      single_wire_data_line_oe,
  // High-voltage programming pulse detected on the line.
  input  wire logic program_pulse
);

  // Identity word, family code in the low byte so it goes out first.
  localparam logic [7:0]  ID_CRC  = crc8_of56({SERIAL, FAMILY_CODE});
  localparam logic [63:0] ID_WORD = {ID_CRC, SERIAL, FAMILY_CODE};

  // Presence delay keeps its ratio to the sample point, so a shortened slot stays consistent.
  localparam int PRES_DELAY_CYCLES = PRES_DELAY_CYC * SAMPLE_CYCLES / SAMPLE_CYC;

  // Bit layer state.
  logic             line_prev;      // Line level one cycle ago.
  logic [CNT_W-1:0] low_cnt;        // Length of the current low phase.
  logic [CNT_W-1:0] slot_cnt;       // Cycles since the slot's falling edge.
  logic             slot_act;       // A bit slot is being timed.
  logic             drive_low;      // Holding the line low for a zero bit.
  logic             pres_wait;      // Waiting before the presence pulse.
  logic             pres_on;        // Presence pulse being driven.
  logic [CNT_W-1:0] pres_cnt;       // Presence timing counter.
  logic             next_line_prev;
  logic [CNT_W-1:0] next_low_cnt;
  logic [CNT_W-1:0] next_slot_cnt;
  logic             next_slot_act;
  logic             next_drive_low;
  logic             next_pres_wait;
  logic             next_pres_on;
  logic [CNT_W-1:0] next_pres_cnt;
  logic             fall;           // Falling edge of the line.
  logic             rst_evt;        // End of a reset pulse.
  logic             bit_evt;        // Sample point of a slot.
  logic             tx_mode;        // Interpreter is sending bits.

  // Command interpreter state.
  owe_state_t  state;               // Interpreter state.
  logic        selected;            // Identity phase passed.
  logic        mismatch;            // Identity compare failed.
  logic        crc_cmd;             // CRC being sent is the command CRC.
  logic [7:0]  cmd;                 // Function command in progress.
  logic [15:0] addr;                // Current byte address.
  logic [7:0]  rx_byte;             // Receive shifter.
  logic [7:0]  hold_buf;            // One-byte programming buffer.
  logic [63:0] tx_shift;            // Transmit shifter, bit 0 goes next.
  logic [5:0]  bit_cnt;             // Bit index within the current field.
  logic [15:0] crc;                 // Running 16-bit check.
  owe_state_t  next_state;
  logic        next_selected;
  logic        next_mismatch;
  logic        next_crc_cmd;
  logic [7:0]  next_cmd;
  logic [15:0] next_addr;
  logic [7:0]  next_rx_byte;
  logic [7:0]  next_hold_buf;
  logic [63:0] next_tx_shift;
  logic [5:0]  next_bit_cnt;
  logic [15:0] next_crc;
  logic        commit;              // Program the buffer into memory.

  // Data field and status bytes.
  logic [7:0] data_mem [DATA_BYTES];
  logic [7:0] status_mem [STATUS_BYTES];

  // True when an address lies in the selected space.
  function automatic logic in_rng(input logic [15:0] a, input logic st);
    return st ? (a >= STATUS_BASE && a < STATUS_BASE + 16'(STATUS_BYTES))
              : (a < 16'(DATA_BYTES));
  endfunction

  // Byte stored at an address; erased value out of range.
  function automatic logic [7:0] byte_at(input logic [15:0] a, input logic st);
    if (!in_rng(a, st)) begin
      return ERASED_BYTE;
    end
    return st ? status_mem[a[2:0]] : data_mem[a[7:0]];
  endfunction

  // Edges and events derived from the registered line.
  assign fall    = line_prev & ~single_wire_data_line_in;
  assign rst_evt = ~line_prev & single_wire_data_line_in & (low_cnt >= CNT_W'(RESET_CYCLES));
  assign bit_evt = slot_act && (slot_cnt == CNT_W'(SAMPLE_CYCLES));
  assign tx_mode = (state == ST_ROMRD) || (state == ST_CRC) || (state == ST_DATA);

  // The device only ever pulls low; the pull-up makes the high level.
  assign single_wire_data_line_out = 1'b0;
  assign single_wire_data_line_oe  = pres_on | drive_low;

  // Bit layer: low length, slot timing, and presence pulse.
  always_comb begin
    next_line_prev = single_wire_data_line_in;
    next_low_cnt   = single_wire_data_line_in ? '0 :
                     ((low_cnt == '1) ? low_cnt : low_cnt + 1'b1);
    next_slot_cnt  = slot_cnt;
    next_slot_act  = slot_act;
    next_drive_low = drive_low;
    next_pres_wait = pres_wait;
    next_pres_on   = pres_on;
    next_pres_cnt  = pres_cnt;
    if (rst_evt) begin
      // A reset pulse ends: drop any slot and schedule presence.
      next_slot_act  = 1'b0;
      next_drive_low = 1'b0;
      next_pres_wait = 1'b1;
      next_pres_cnt  = '0;
    end else if (pres_wait) begin
      next_pres_cnt = pres_cnt + 1'b1;
      if (pres_cnt == CNT_W'(PRES_DELAY_CYCLES - 1)) begin
        next_pres_wait = 1'b0;
        next_pres_on   = 1'b1;
        next_pres_cnt  = '0;
      end
    end else if (pres_on) begin
      // Our own low is not a slot, so falls are ignored here.
      next_pres_cnt = pres_cnt + 1'b1;
      if (pres_cnt == CNT_W'(PRES_CYCLES - 1)) begin
        next_pres_on = 1'b0;
      end
    end else if (fall) begin
      // The host's start of a slot; a zero to send is pulled at once.
      next_slot_act  = 1'b1;
      next_slot_cnt  = '0;
      next_drive_low = tx_mode & ~tx_shift[0];
    end else if (slot_act) begin
      next_slot_cnt = slot_cnt + 1'b1;
      if (bit_evt) begin
        next_slot_act  = 1'b0;
        next_drive_low = 1'b0;
      end
    end
  end

  // Registers of the bit layer.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_prev <= 1'b1;
      low_cnt   <= '0;
      slot_cnt  <= '0;
      slot_act  <= 1'b0;
      drive_low <= 1'b0;
      pres_wait <= 1'b0;
      pres_on   <= 1'b0;
      pres_cnt  <= '0;
    end else begin
      line_prev <= next_line_prev;
      low_cnt   <= next_low_cnt;
      slot_cnt  <= next_slot_cnt;
      slot_act  <= next_slot_act;
      drive_low <= next_drive_low;
      pres_wait <= next_pres_wait;
      pres_on   <= next_pres_on;
      pres_cnt  <= next_pres_cnt;
    end
  end

  // Command interpreter: one step per sampled bit.
  always_comb begin
    logic       b;
    logic       st;
    logic [7:0] nb;
    b             = single_wire_data_line_in;
    st            = (cmd == CMD_READ_STAT) || (cmd == CMD_WRITE_ST);
    nb            = {b, rx_byte[7:1]};
    next_state    = state;
    next_selected = selected;
    next_mismatch = mismatch;
    next_crc_cmd  = crc_cmd;
    next_cmd      = cmd;
    next_addr     = addr;
    next_rx_byte  = rx_byte;
    next_hold_buf = hold_buf;
    next_tx_shift = tx_shift;
    next_bit_cnt  = bit_cnt + 6'h01;
    next_crc      = crc;
    commit        = 1'b0;
    if (rst_evt) begin
      // Any state returns to the identity phase, selection cleared.
      next_state    = ST_ROMC;
      next_selected = 1'b0;
      next_addr     = '0;
      next_bit_cnt  = '0;
    end else if (state == ST_PROG) begin
      // The buffer is ANDed into the array only on the program pulse.
      if (program_pulse) begin
        commit     = 1'b1;
        next_state = ST_ONES;
      end
    end else if (bit_evt) begin
      next_rx_byte  = nb;
      next_tx_shift = tx_shift >> 1;
      case (state)
        ST_ROMC: begin
          if (bit_cnt == 6'h07) begin
            next_bit_cnt = '0;
            case (nb)
              CMD_READ_ID: begin
                next_state    = ST_ROMRD;
                next_tx_shift = ID_WORD;
              end
              CMD_MATCH_ID: begin
                next_state    = ST_MATCH;
                next_tx_shift = ID_WORD;
                next_mismatch = 1'b0;
              end
              CMD_SKIP_ID: begin
                next_state    = ST_FUNC;
                next_selected = 1'b1;
                next_crc      = '0;
              end
              default: next_state = ST_WAIT;
            endcase
          end
        end
        ST_ROMRD, ST_MATCH: begin
          // Matching compares each host bit against the stored identity.
          if (state == ST_MATCH && b != tx_shift[0]) begin
            next_mismatch = 1'b1;
          end
          if (bit_cnt == 6'(ID_BITS - 1)) begin
            next_bit_cnt  = '0;
            next_crc      = '0;
            next_selected = (state == ST_ROMRD) || (!next_mismatch);
            next_state    = next_selected ? ST_FUNC : ST_WAIT;
          end
        end
        ST_FUNC: begin
          next_crc = crc16_bit(crc, b);
          if (bit_cnt == 6'h07) begin
            next_bit_cnt = '0;
            next_cmd     = nb;
            // Without a prior selection no function command is honoured.
            if (selected && (nb == CMD_READ_MEM || nb == CMD_READ_STAT ||
                             nb == CMD_WRITE_MEM || nb == CMD_WRITE_ST)) begin
              next_state = ST_ADDR;
            end else begin
              next_state = ST_WAIT;
            end
          end
        end
        ST_ADDR: begin
          next_crc = crc16_bit(crc, b);
          if (bit_cnt == 6'h07) begin
            next_addr[7:0] = nb;
          end
          if (bit_cnt == 6'h0F) begin
            next_addr[15:8] = nb;
            next_bit_cnt    = '0;
            if (cmd == CMD_READ_MEM) begin
              // Field CRC covers data bytes only, so it restarts here.
              next_crc      = '0;
              next_crc_cmd  = 1'b0;
              next_state    = in_rng(next_addr, 1'b0) ? ST_DATA : ST_CRC;
              next_tx_shift = in_rng(next_addr, 1'b0) ?
                              {56'hFFFF_FFFF_FFFF_FF, byte_at(next_addr, 1'b0)} : '0;
            end else if (cmd == CMD_READ_STAT) begin
              next_state    = ST_CRC;
              next_crc_cmd  = 1'b1;
              next_tx_shift = {48'hFFFF_FFFF_FFFF, next_crc};
            end else begin
              next_state = ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          next_crc = crc16_bit(crc, b);
          if (bit_cnt == 6'h07) begin
            next_bit_cnt  = '0;
            next_hold_buf = nb;
            next_state    = ST_CRC;
            next_crc_cmd  = 1'b1;
            next_tx_shift = {48'hFFFF_FFFF_FFFF, next_crc};
          end
        end
        ST_CRC: begin
          if (bit_cnt == 6'h0F) begin
            next_bit_cnt = '0;
            next_crc     = '0;
            if (!crc_cmd) begin
              next_state = ST_ONES;
            end else if (cmd == CMD_READ_STAT) begin
              // Status data follows its command CRC, read live from the array.
              next_crc_cmd  = 1'b0;
              next_state    = in_rng(addr, 1'b1) ? ST_DATA : ST_CRC;
              next_tx_shift = in_rng(addr, 1'b1) ?
                              {56'hFFFF_FFFF_FFFF_FF, byte_at(addr, 1'b1)} : '0;
            end else begin
              next_state = ST_PROG;
            end
          end
        end
        ST_DATA: begin
          next_crc = crc16_bit(crc, tx_shift[0]);
          if (bit_cnt == 6'h07) begin
            next_bit_cnt = '0;
            next_addr    = addr + 16'h0001;
            if (in_rng(next_addr, st)) begin
              next_tx_shift = {56'hFFFF_FFFF_FFFF_FF, byte_at(next_addr, st)};
            end else begin
              next_state    = ST_CRC;
              next_tx_shift = {48'hFFFF_FFFF_FFFF, next_crc};
            end
          end
        end
        default: next_bit_cnt = bit_cnt; // Waiting for a reset pulse.
      endcase
    end else begin
      next_bit_cnt = bit_cnt;
    end
  end

  // Registers of the interpreter.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_WAIT;
      selected <= 1'b0;
      mismatch <= 1'b0;
      crc_cmd  <= 1'b0;
      cmd      <= 8'h00;
      addr     <= 16'h0000;
      rx_byte  <= 8'h00;
      hold_buf <= ERASED_BYTE;
      tx_shift <= '1;
      bit_cnt  <= 6'h00;
      crc      <= 16'h0000;
    end else begin
      state    <= next_state;
      selected <= next_selected;
      mismatch <= next_mismatch;
      crc_cmd  <= next_crc_cmd;
      cmd      <= next_cmd;
      addr     <= next_addr;
      rx_byte  <= next_rx_byte;
      hold_buf <= next_hold_buf;
      tx_shift <= next_tx_shift;
      bit_cnt  <= next_bit_cnt;
      crc      <= next_crc;
    end
  end

  // Storage; programming can only clear bits, like a real OTP cell.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DATA_BYTES; i++) data_mem[i] <= ERASED_BYTE;
      for (int i = 0; i < STATUS_BYTES; i++) status_mem[i] <= ERASED_BYTE;
    end else if (commit && in_rng(addr, cmd == CMD_WRITE_ST)) begin
      if (cmd == CMD_WRITE_ST) begin
        status_mem[addr[2:0]] <= status_mem[addr[2:0]] & hold_buf;
      end else begin
        data_mem[addr[7:0]] <= data_mem[addr[7:0]] & hold_buf;
      end
    end
  end

  a_select_gate: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_ADDR) |-> selected)
    else $error("Function phase entered without selection.");
  a_read_id_load: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_ROMC && next_state == ST_ROMRD) |=> (tx_shift == ID_WORD))
    else $error("Identity not loaded for read.");
  a_match_miss: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_MATCH && bit_evt && !rst_evt && single_wire_data_line_in != tx_shift[0])
    |=> (mismatch || state == ST_WAIT))
    else $error("Identity mismatch not recorded.");
  a_skip_select: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_ROMC && bit_evt && !rst_evt && bit_cnt == 6'h07 &&
     {single_wire_data_line_in, rx_byte[7:1]} == CMD_SKIP_ID) |=> (state == ST_FUNC && selected))
    else $error("Skip command did not select.");
  a_reset_return: assert property (@(posedge clock) disable iff (!rst_n)
    rst_evt |=> (state == ST_ROMC && !selected && addr == 16'h0000))
    else $error("Reset pulse did not restart interpreter.");
  a_ones_release: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_ONES && $past(state) == ST_ONES && !pres_on) |-> !single_wire_data_line_oe)
    else $error("Line pulled after final check.");
  a_zero_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (fall && !pres_on && !pres_wait && !rst_evt && tx_mode && !tx_shift[0])
    |=> single_wire_data_line_oe [*8])
    else $error("Zero bit not held low.");
  a_lsb_shift: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_DATA && bit_evt && !rst_evt && bit_cnt != 6'h07)
    |=> (tx_shift[6:0] == $past(tx_shift[7:1])))
    else $error("Data not shifted low bit first.");
  a_field_end: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_DATA && cmd == CMD_READ_MEM && bit_evt && !rst_evt && bit_cnt == 6'h07 &&
     addr == 16'(DATA_BYTES - 1)) |=> (state == ST_CRC && !crc_cmd))
    else $error("Field check did not follow last byte.");
  a_prog_commit: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_PROG && program_pulse && !rst_evt) |=> (state == ST_ONES))
    else $error("Program pulse not taken.");

endmodule

// ==== owe_host.sv ====
module owe_host (
  // Clock.
  input  wire logic clock,
  // Device side of the line.
  input  wire logic dev_oe,
  // Resolved line level.
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;

  // Slot timing in clock cycles, sized for the bench's shortened sample point of 40.
  localparam int T_START = 4;    // Low start of every slot.
  localparam int T_LOOK  = 16;   // From the level to the host's own read sample.
  localparam int T_HOLD  = 30;   // Level held on, well past the device sample point.
  localparam int T_GAP   = 6;    // Released recovery before the next slot.
  localparam int T_WATCH = 200;  // Window in which the presence answer must show.

  logic host_low;  // High while the host pulls the line down.

  // Wire-AND with a pull-up, so a released line reads high.
  assign line = ~(host_low | dev_oe);

  initial host_low = 1'b0;

  // One slot: a start period low, then the level, held past the device sample point.
  task automatic slot(input logic b, output logic seen);
    @(negedge clock);
    host_low = 1'b1;
    repeat (T_START) @(negedge clock);
    host_low = ~b;
    repeat (T_LOOK) @(negedge clock);
    seen = line;
    repeat (T_HOLD) @(negedge clock);
    host_low = 1'b0;
    repeat (T_GAP) @(negedge clock);
  endtask

  // Sends one byte, low bit first.
  task automatic wr(input logic [7:0] d);
    logic s;
    for (int i = 0; i < 8; i++) begin
      slot(d[i], s);
    end
  endtask

  // Reads n bits into v, low bit first.
  task automatic rd(input int n, output logic [15:0] v);
    logic s;
    v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      slot(1'b1, s);
      v[i] = s;
    end
  endtask

  // Long low pulse, then a bounded watch for the presence answer.
  task automatic line_reset(input int low_cyc, output logic pres);
    pres = 1'b0;
    @(negedge clock);
    host_low = 1'b1;
    repeat (low_cyc) @(negedge clock);
    host_low = 1'b0;
    for (int i = 0; i < T_WATCH; i++) begin
      @(negedge clock);
      if (line === 1'b0) begin
        pres = 1'b1;
      end
    end
  endtask
endmodule

// ==== otp_eprom_one_wire_cmd_bench.sv ====
module otp_eprom_one_wire_cmd_bench import owe_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // The reset pulse is shortened but stays above any bit slot's low time.
  localparam int          RST_LOW = 200;
  // Sample point shortened so the run stays short; the host's slot timing is sized for it.
  localparam int          SMP     = 40;
  localparam logic [7:0]  FAM     = 8'h3C;             // Arbitrary value.
  localparam logic [47:0] SER     = 48'h0000_0000_00A5; // Arbitrary value.

  // Row of an ordinary read case.
  typedef struct packed {
    logic [7:0]  func;   // Function command.
    logic [15:0] addr;   // Start address.
    logic [7:0]  ndata;  // Data bytes before the closing check word.
  } owe_row_t;

  owe_row_t    rows [4] = '{'{8'hF0, 16'h00BF, 8'h01}, '{8'hF0, 16'h00C0, 8'h00},
                            '{8'hAA, 16'h0107, 8'h01}, '{8'hAA, 16'h0108, 8'h00}};
  logic        clock;        // System clock.
  logic        rst_n;        // Active-low reset.
  logic        line;         // Resolved line level.
  logic        dev_oe;       // Device pull-down enable.
  logic        dev_out;      // Device drive value.
  logic        pres;         // Presence seen.
  logic [15:0] v;            // Value read back.
  logic [15:0] c;            // Expected check word.
  logic [63:0] id;           // Identity sent for a match.
  logic [15:0] a;            // Address of a programmed byte.
  logic [7:0]  f;            // Function command of a scenario.
  logic        program_pulse; // Programming voltage present.
  int          err_total;    // Mismatches.
  int          checks_done;  // Comparisons.

  owe_cmd #(.FAMILY_CODE(FAM), .SERIAL(SER), .RESET_CYCLES(RST_LOW), .PRES_CYCLES(60),
            .SAMPLE_CYCLES(SMP)) i_dut (
    .clock(clock), .rst_n(rst_n), .single_wire_data_line_in(line),
    .single_wire_data_line_out(dev_out), .single_wire_data_line_oe(dev_oe),
    .program_pulse(program_pulse));

  owe_host i_host (.clock(clock), .dev_oe(dev_oe), .line(line));

  // Bench copy of the 16-bit check, written apart from the design's own.
  function automatic logic [15:0] crc_add(input logic [15:0] c0, input logic [7:0] d);
    logic [15:0] r;
    r = c0;
    for (int i = 0; i < 8; i++) begin
      r = ((r[0] ^ d[i]) == 1'b1) ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction

  // Bench copy of the identity check byte, family code first, low bit first.
  function automatic logic [7:0] crc8_id(input logic [55:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 56; i++) begin
      r = ((r[0] ^ d[i]) == 1'b1) ? ((r >> 1) ^ 8'h8C) : (r >> 1);
    end
    return r;
  endfunction

  // Compares and counts.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the verdict and stops.
  task automatic end_sim();
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Line reset, presence check, then the first byte.
  task automatic go(input logic [7:0] first);
    i_host.line_reset(RST_LOW + 100, pres);
    check("presence", {15'h0000, pres}, 16'h0001);
    i_host.wr(first);
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Main sequence; every wait is a fixed or bounded count.
  initial begin
    err_total = 0;
    checks_done = 0;
    program_pulse = 1'b0;
    rst_n = 1'b0;
    repeat (10) @(negedge clock);
    check("enable in reset", {15'h0000, dev_oe}, 16'h0000);
    check("drive value", {15'h0000, dev_out}, 16'h0000);
    rst_n = 1'b1;
    // Ordinary reads after a skip selection.
    for (int r = 0; r < 4; r++) begin
      go(CMD_SKIP_ID);
      i_host.wr(rows[r].func);
      i_host.wr(rows[r].addr[7:0]);
      i_host.wr(rows[r].addr[15:8]);
      if (rows[r].func == CMD_READ_STAT) begin
        c = crc_add(crc_add(16'h0000, rows[r].func), rows[r].addr[7:0]);
        i_host.rd(16, v);
        check("command check word", v, crc_add(c, rows[r].addr[15:8]));
      end
      c = 16'h0000;
      for (int k = 0; k < rows[r].ndata; k++) begin
        i_host.rd(8, v);
        check("data byte", v, 16'h00FF);
        c = crc_add(c, 8'hFF);
      end
      i_host.rd(16, v);
      check("closing check word", v, c);
      i_host.rd(8, v);
      check("trailing ones", v, 16'h00FF);
    end
    // A function command without selection is ignored, so no check word comes.
    go(CMD_READ_STAT);
    i_host.wr(8'h07);
    i_host.wr(8'h01);
    i_host.rd(16, v);
    check("unselected reply", v, 16'hFFFF);
    // A full identity match selects; a wrong check byte leaves the device deaf.
    for (int m = 0; m < 2; m++) begin
      id = {crc8_id({SER, FAM}) ^ 8'(m), SER, FAM};
      go(CMD_MATCH_ID);
      for (int k = 0; k < 8; k++) begin
        i_host.wr(id[8*k +: 8]);
      end
      i_host.wr(CMD_READ_STAT);
      i_host.wr(8'h07);
      i_host.wr(8'h01);
      i_host.rd(16, v);
      c = crc_add(crc_add(crc_add(16'h0000, CMD_READ_STAT), 8'h07), 8'h01);
      check("match reply", v, (m == 0) ? c : 16'hFFFF);
    end
    // Program a data byte and a status byte, then read each back in a fresh frame.
    for (int m = 0; m < 2; m++) begin
      a = (m == 0) ? 16'h0005 : 16'h0103;
      f = (m == 0) ? CMD_WRITE_MEM : CMD_WRITE_ST;
      go(CMD_SKIP_ID);
      i_host.wr(f);
      i_host.wr(a[7:0]);
      i_host.wr(a[15:8]);
      i_host.wr(8'h5A);
      i_host.rd(16, v);
      c = crc_add(crc_add(crc_add(crc_add(16'h0000, f), a[7:0]), a[15:8]), 8'h5A);
      check("write check word", v, c);
      // The pulse goes out only on an agreeing check word; otherwise the next reset drops the write unprogrammed.
      @(negedge clock);
      if (v === c) begin
        program_pulse = 1'b1;
      end
      repeat (3) @(negedge clock);
      program_pulse = 1'b0;
      f = (m == 0) ? CMD_READ_MEM : CMD_READ_STAT;
      go(CMD_SKIP_ID);
      i_host.wr(f);
      i_host.wr(a[7:0]);
      i_host.wr(a[15:8]);
      if (m == 1) begin
        i_host.rd(16, v);  // Command check word, compared in the rows above.
      end
      i_host.rd(8, v);
      check("programmed byte", v, 16'h005A);
    end
    // A read cut short by a line reset; the next frame starts in the identity phase.
    go(CMD_SKIP_ID);
    i_host.wr(CMD_READ_MEM);
    i_host.wr(8'hBE);
    i_host.wr(8'h00);
    i_host.rd(8, v);
    check("data before abort", v, 16'h00FF);
    go(CMD_READ_ID);
    i_host.rd(16, v);
    check("identity head", v, {SER[7:0], FAM});
    end_sim();
  end
endmodule
